// ---- rtl/can_map_params.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef CAN_MAP_PARAMS_SVH
`define CAN_MAP_PARAMS_SVH
`define CM_OFS_CTRL 8'h00
`define CM_OFS_RATE 8'h04
`define CM_OFS_RX_ID 8'h08
`define CM_OFS_RX_FIELD 8'h0C
`define CM_OFS_RX_MUX 8'h10
`define CM_OFS_RX_TMO 8'h14
`define CM_OFS_RX_REPL 8'h18
`define CM_OFS_RX_GAIN 8'h1C
`define CM_OFS_RX_OFFS 8'h20
`define CM_OFS_RX_RAW 8'h24
`define CM_OFS_RX_PHYS 8'h28
`define CM_OFS_STATUS 8'h2C
`define CM_OFS_TX_ID 8'h30
`define CM_OFS_TX_PER 8'h34
`define CM_OFS_TX_LO 8'h38
`define CM_OFS_TX_HI 8'h3C
`define CM_OFS_TX_MUX 8'h40
// Field positions
`define CM_ID_EXT 31
`define CM_ID_MUX 30
`define CM_ID_BUS 29
`define CM_FLD_BITREP 16
`define CM_FLD_MSB 17
`define CM_FLD_SIGNED 18
`define CM_TMO_REPL 31
`define CM_TXM_EN 31
// Bit rate limits in kbaud and reset value
`define CM_RATE_MIN 16'h007D
`define CM_RATE_MAX 16'h03E8
`define CM_RATE_RST 16'h01F4
`define CM_GAIN_RST 16'h0100
`define CM_MAX_DLC 4'h8
// Timing: one timebase tick of 1 ms at a 10 ns clock
`define CM_TICK_NS 1000000
`define CM_CLK_NS 10
`define CM_TICK_CYCLES (`CM_TICK_NS / `CM_CLK_NS)
`endif

// ---- rtl/can_map_pkg.sv ----
// Types shared by the CAN signal mapper
package can_map_pkg;
  typedef struct packed {
    logic valid;
    logic bus;
    logic ext;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } can_frame_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_GATE = 3'b010,
    TX_PERI = 3'b100
  } tx_src_e;
endpackage

// ---- rtl/can_signal_mapper.sv ----
// CAN signal mapper: receive channel, periodic transmit, gateway, APB
`timescale 1ns/1ps
`include "can_map_params.svh"

// How it works
// RULE_01: Each bus has a bit rate register accepting 125 to 1000 kbaud.
// RULE_02: All nodes on a bus share one rate; the block drives one per bus.
// RULE_03: Each message picks standard or extended identifier by a flag.
// RULE_04: Payloads hold at most eight bytes; longer lengths are clamped.
// RULE_05: With multiplexing, one payload byte carries the row counter.
// RULE_06: The row counter byte position is a configuration field.
// RULE_07: Mux data is used only in frames whose counter equals its row.
// RULE_08: Receive field is taken by configured start, length and format.
// RULE_09: Receive field position is in bytes or in bits, per setting.
// RULE_10: On timeout with replacement on, the replacement raw value is used.
// RULE_11: Physical value is raw times gain, then plus offset.
// RULE_12: Transmit frame repeats at its interval, with optional row counter.
// RULE_13: Frames from one bus can be forwarded onto the other bus.
// RULE_14: A channel updates only on matching identifier value and format.
module can_signal_mapper #(
  parameter int TICK_CYCLES = `CM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire can_map_pkg::can_frame_s rx_frame,
  output can_map_pkg::can_frame_s tx_frame,
  input wire logic tx_ready,
  output logic [15:0] rate_bus0,
  output logic [15:0] rate_bus1,
  output logic [31:0] phys_value,
  output logic phys_strobe
);
  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES >= 2**20) begin
      $error("can_signal_mapper: TICK_CYCLES out of range");
    end
  end

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic gw_en;
    logic gw_src;
    logic [15:0] rate0;
    logic [15:0] rate1;
    logic [31:0] rx_id;
    logic [31:0] rx_fld;
    logic [2:0] rx_mpos;
    logic [7:0] rx_row;
    logic repl_en;
    logic [15:0] tmo;
    logic [31:0] repl;
    logic [15:0] gain;
    logic [31:0] offs;
    logic [31:0] raw;
    logic [31:0] phys;
    logic raw_new;
    logic phys_new;
    logic got;
    logic timed_out;
    logic [15:0] tmo_cnt;
    logic [19:0] tick_cnt;
    logic [31:0] tx_id;
    logic [15:0] tx_per;
    logic [15:0] per_cnt;
    logic [63:0] tx_data;
    logic tx_mux_en;
    logic [2:0] tx_mpos;
    logic [7:0] tx_rows;
    logic [7:0] tx_drow;
    logic [3:0] tx_dlc;
    logic [7:0] row_cnt;
    logic tx_due;
    can_map_pkg::tx_src_e src;
    can_map_pkg::can_frame_s out;
    can_map_pkg::can_frame_s gw;
    logic [7:0] gw_drops;
  } state_s;

  state_s q;
  state_s d;
  logic [31:0] field;
  logic [47:0] prod;

  // Byte of the payload at a row counter position
  function automatic logic [7:0] pick_byte(input logic [63:0] p,
                                           input logic [2:0] pos);
    pick_byte = p[{pos, 3'b000} +: 8];
  endfunction

  // Bytes beyond the frame length read as zero
  function automatic logic [63:0] clip(input logic [63:0] p,
                                       input logic [3:0] dlc);
    clip = '0;
    for (int b = 0; b < 8; b++) begin
      if (b < int'(dlc)) begin
        clip[b*8 +: 8] = p[b*8 +: 8];
      end
    end
  endfunction

  field_extract #(
    .W(32)
  ) u_extract (
    .payload(clip(rx_frame.data, rx_frame.dlc)),
    .start(q.rx_fld[5:0]),
    .len(q.rx_fld[13:8]),
    .bit_rep(q.rx_fld[`CM_FLD_BITREP]),
    .msb_first(q.rx_fld[`CM_FLD_MSB]),
    .is_signed(q.rx_fld[`CM_FLD_SIGNED]),
    .value(field)
  );

  // Gain is signed with eight fraction bits
  assign prod = $signed(q.raw) * $signed(q.gain); // see RULE_11

  logic apb_wr;
  logic apb_hit;
  logic rx_match;
  logic gw_take;
  logic tick;
  assign apb_wr = psel && penable && pwrite;
  assign tick = (q.tick_cnt == 20'(TICK_CYCLES - 1));

  // Identifier value, format and bus must all agree
  always_comb begin
    rx_match = rx_frame.valid && q.rx_en
      && rx_frame.ext == q.rx_id[`CM_ID_EXT]
      && rx_frame.bus == q.rx_id[`CM_ID_BUS]
      && (rx_frame.ext ? rx_frame.id == q.rx_id[28:0]
          : rx_frame.id[10:0] == q.rx_id[10:0]); // see RULE_14 RULE_03
    if (q.rx_id[`CM_ID_MUX]
        && pick_byte(rx_frame.data, q.rx_mpos) != q.rx_row) begin
      rx_match = 1'b0; // see RULE_05 RULE_07
    end
    gw_take = rx_frame.valid && q.gw_en && rx_frame.bus == q.gw_src;
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    d.raw_new = 1'b0;
    d.phys_new = q.raw_new;
    d.tick_cnt = tick ? 20'h0_0000 : q.tick_cnt + 20'h0_0001;
    // Register writes take effect in the access phase
    if (apb_wr) begin
      unique case (paddr)
        `CM_OFS_CTRL: begin
          d.rx_en = pwdata[0];
          d.tx_en = pwdata[1];
          d.gw_en = pwdata[2];
          d.gw_src = pwdata[3];
        end
        `CM_OFS_RATE: begin
          // Out-of-range rates are ignored to keep the bus usable
          if (pwdata[15:0] >= `CM_RATE_MIN && pwdata[15:0] <= `CM_RATE_MAX)
            d.rate0 = pwdata[15:0]; // see RULE_01
          if (pwdata[31:16] >= `CM_RATE_MIN && pwdata[31:16] <= `CM_RATE_MAX)
            d.rate1 = pwdata[31:16]; // see RULE_01
        end
        `CM_OFS_RX_ID: d.rx_id = pwdata;
        `CM_OFS_RX_FIELD: d.rx_fld = pwdata;
        `CM_OFS_RX_MUX: begin
          d.rx_mpos = pwdata[2:0]; // see RULE_06
          d.rx_row = pwdata[15:8];
        end
        `CM_OFS_RX_TMO: begin
          d.tmo = pwdata[15:0];
          d.repl_en = pwdata[`CM_TMO_REPL];
        end
        `CM_OFS_RX_REPL: d.repl = pwdata;
        `CM_OFS_RX_GAIN: d.gain = pwdata[15:0];
        `CM_OFS_RX_OFFS: d.offs = pwdata;
        `CM_OFS_TX_ID: d.tx_id = pwdata;
        `CM_OFS_TX_PER: d.tx_per = pwdata[15:0];
        `CM_OFS_TX_LO: d.tx_data[31:0] = pwdata;
        `CM_OFS_TX_HI: d.tx_data[63:32] = pwdata;
        `CM_OFS_TX_MUX: begin
          d.tx_mpos = pwdata[2:0]; // see RULE_06
          d.tx_rows = pwdata[15:8];
          d.tx_drow = pwdata[23:16];
          d.tx_dlc = (pwdata[27:24] > `CM_MAX_DLC) ? `CM_MAX_DLC
                     : pwdata[27:24]; // see RULE_04
          d.tx_mux_en = pwdata[`CM_TXM_EN];
        end
        default: d.gw_drops = q.gw_drops;
      endcase
    end
    // Timeout counts whole ticks since the last matching frame
    if (rx_match) begin
      d.raw = field; // see RULE_08
      d.raw_new = 1'b1;
      d.got = 1'b1;
      d.timed_out = 1'b0;
      d.tmo_cnt = 16'h0000;
    end else if (tick && !q.timed_out && q.tmo != 16'h0000) begin
      if (q.tmo_cnt + 16'h0001 >= q.tmo) begin
        d.timed_out = 1'b1;
        if (q.repl_en) begin
          d.raw = q.repl; // see RULE_10
          d.raw_new = 1'b1;
        end
      end else begin
        d.tmo_cnt = q.tmo_cnt + 16'h0001;
      end
    end
    if (q.raw_new) begin
      d.phys = prod[39:8] + q.offs; // see RULE_11
    end
    // Gateway: one frame held; a new one while held is dropped
    if (gw_take) begin
      if (!q.gw.valid) begin
        d.gw = rx_frame; // see RULE_13
        d.gw.bus = ~rx_frame.bus;
        d.gw.dlc = (rx_frame.dlc > `CM_MAX_DLC) ? `CM_MAX_DLC
                   : rx_frame.dlc; // see RULE_04
      end else begin
        d.gw_drops = q.gw_drops + 8'h01;
      end
    end
    // Interval counter flags a due message in ticks
    if (q.tx_en && tick && q.tx_per != 16'h0000) begin
      if (q.per_cnt + 16'h0001 >= q.tx_per) begin
        d.per_cnt = 16'h0000;
        d.tx_due = 1'b1; // see RULE_12
      end else begin
        d.per_cnt = q.per_cnt + 16'h0001;
      end
    end
    // Output slot: hold until taken, gateway first
    unique case (q.src)
      can_map_pkg::TX_IDLE: begin
        if (q.gw.valid) begin
          d.out = q.gw;
          d.gw.valid = 1'b0;
          d.src = can_map_pkg::TX_GATE;
        end else if (q.tx_due) begin
          d.out.valid = 1'b1;
          d.out.bus = q.tx_id[`CM_ID_BUS];
          d.out.ext = q.tx_id[`CM_ID_EXT]; // see RULE_03
          d.out.id = q.tx_id[`CM_ID_EXT] ? q.tx_id[28:0]
                     : {18'h0_0000, q.tx_id[10:0]};
          d.out.dlc = q.tx_dlc;
          d.out.data = q.tx_data;
          if (q.tx_mux_en) begin
            if (q.row_cnt != q.tx_drow) begin
              d.out.data = '0; // see RULE_07
            end
            d.out.data[{q.tx_mpos, 3'b000} +: 8] = q.row_cnt; // see RULE_05
            d.row_cnt = (q.row_cnt + 8'h01 >= q.tx_rows) ? 8'h00
                        : q.row_cnt + 8'h01; // see RULE_12
          end
          d.out.data = clip(d.out.data, q.tx_dlc);
          d.tx_due = 1'b0;
          d.src = can_map_pkg::TX_PERI;
        end
      end
      can_map_pkg::TX_GATE, can_map_pkg::TX_PERI: begin
        if (tx_ready) begin
          d.out.valid = 1'b0;
          d.src = can_map_pkg::TX_IDLE;
        end
      end
      default: d.src = can_map_pkg::TX_IDLE;
    endcase
    // A period ending while the last due frame is loaded must not be lost
    if (q.tx_en && tick && q.tx_per != 16'h0000
        && q.per_cnt + 16'h0001 >= q.tx_per) begin
      d.tx_due = 1'b1; // see RULE_12
    end
  end

  // One register stage for all state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.rate0 <= `CM_RATE_RST;
      q.rate1 <= `CM_RATE_RST;
      q.gain <= `CM_GAIN_RST;
      q.rx_fld <= 32'h0000_0400;
      q.tx_dlc <= `CM_MAX_DLC;
      q.tx_rows <= 8'h01;
      q.src <= can_map_pkg::TX_IDLE;
    end else begin
      q <= d;
    end
  end

  // Read mux; zero wait states, unmapped offsets answer an error
  always_comb begin
    apb_hit = 1'b1;
    unique case (paddr)
      `CM_OFS_CTRL: prdata = {28'h000_0000, q.gw_src, q.gw_en, q.tx_en,
                              q.rx_en};
      `CM_OFS_RATE: prdata = {q.rate1, q.rate0};
      `CM_OFS_RX_ID: prdata = q.rx_id;
      `CM_OFS_RX_FIELD: prdata = q.rx_fld;
      `CM_OFS_RX_MUX: prdata = {16'h0000, q.rx_row, 5'h00, q.rx_mpos};
      `CM_OFS_RX_TMO: prdata = {q.repl_en, 15'h0000, q.tmo};
      `CM_OFS_RX_REPL: prdata = q.repl;
      `CM_OFS_RX_GAIN: prdata = {16'h0000, q.gain};
      `CM_OFS_RX_OFFS: prdata = q.offs;
      `CM_OFS_RX_RAW: prdata = q.raw;
      `CM_OFS_RX_PHYS: prdata = q.phys;
      `CM_OFS_STATUS: prdata = {16'h0000, q.gw_drops, 5'h00, q.gw.valid,
                                q.timed_out, q.got};
      `CM_OFS_TX_ID: prdata = q.tx_id;
      `CM_OFS_TX_PER: prdata = {16'h0000, q.tx_per};
      `CM_OFS_TX_LO: prdata = q.tx_data[31:0];
      `CM_OFS_TX_HI: prdata = q.tx_data[63:32];
      `CM_OFS_TX_MUX: prdata = {q.tx_mux_en, 3'h0, q.tx_dlc, q.tx_drow,
                                q.tx_rows, 5'h00, q.tx_mpos};
      default: begin
        prdata = 32'h0000_0000;
        apb_hit = 1'b0;
      end
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign tx_frame = q.out;
  // One rate per bus keeps every node on it in step
  assign rate_bus0 = q.rate0; // see RULE_02
  assign rate_bus1 = q.rate1; // see RULE_02
  assign phys_value = q.phys;
  assign phys_strobe = q.phys_new;
endmodule

// ---- rtl/field_extract.sv ----
// Field extraction of a raw value from a CAN payload
`timescale 1ns/1ps
module field_extract #(
  parameter int W = 32
) (
  input wire logic [63:0] payload,
  input wire logic [5:0] start,
  input wire logic [5:0] len,
  input wire logic bit_rep,
  input wire logic msb_first,
  input wire logic is_signed,
  output logic [W-1:0] value
);
  initial begin
    if (W % 8 != 0 || W > 64 || W < 8) begin
      $error("field_extract: W must be a multiple of 8 up to 64");
    end
  end

  // Byte representation scales position and length by eight
  always_comb begin
    logic [5:0] s;
    logic [63:0] sh;
    logic [W-1:0] v;
    int n;
    int nb;
    s = bit_rep ? start : {start[2:0], 3'b000}; // see RULE_09
    n = bit_rep ? int'(len) : int'(len[3:0]) * 8;
    if (n > W) begin
      n = W;
    end
    if (n == 0) begin
      n = 1;
    end
    nb = n / 8;
    sh = payload >> s; // see RULE_08
    v = '0;
    for (int i = 0; i < W; i++) begin
      if (i < n) begin
        v[i] = sh[i];
      end
    end
    value = v;
    // Byte order swap only makes sense for whole bytes
    if (!bit_rep && msb_first) begin
      value = '0;
      for (int k = 0; k < W / 8; k++) begin
        if (k < nb) begin
          value[k*8 +: 8] = v[(nb - 1 - k)*8 +: 8];
        end
      end
    end
    if (is_signed && n < W && value[n-1]) begin
      for (int i = 0; i < W; i++) begin
        if (i >= n) begin
          value[i] = 1'b1;
        end
      end
    end
  end
endmodule

// ---- tb/can_map_sva.sv ----
// Port timing checks for the CAN signal mapper
`timescale 1ns/1ps
`include "can_map_params.svh"
module can_map_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire can_map_pkg::can_frame_s tx_frame,
  input wire logic tx_ready,
  input wire logic [15:0] rate_bus0,
  input wire logic [15:0] rate_bus1,
  input wire logic [31:0] phys_value,
  input wire logic phys_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A held frame and its release are the two steps of a handover
  sequence s_tx_wait;
    tx_frame.valid && !tx_ready;
  endsequence
  sequence s_tx_take;
    tx_frame.valid && tx_ready;
  endsequence
  a_rate0_range: assert property (rate_bus0 >= `CM_RATE_MIN &&
    rate_bus0 <= `CM_RATE_MAX) else $error("bus0 rate out of range");
  a_rate1_range: assert property (rate_bus1 >= `CM_RATE_MIN &&
    rate_bus1 <= `CM_RATE_MAX) else $error("bus1 rate out of range");
  a_rate0_write: assert property ($changed(rate_bus0) |->
    $past(psel && penable && pwrite && paddr == `CM_OFS_RATE))
    else $error("bus0 rate changed without a write");
  a_rate1_write: assert property ($changed(rate_bus1) |->
    $past(psel && penable && pwrite && paddr == `CM_OFS_RATE))
    else $error("bus1 rate changed without a write");
  a_tx_hold: assert property (s_tx_wait |=> $stable(tx_frame))
    else $error("frame changed before it was taken");
  a_tx_release: assert property (s_tx_take |=> !tx_frame.valid)
    else $error("frame still offered after it was taken");
  a_dlc_limit: assert property (tx_frame.valid |->
    tx_frame.dlc <= `CM_MAX_DLC) else $error("frame longer than eight bytes");
  a_phys_strobe: assert property ($changed(phys_value) |->
    phys_strobe) else $error("value changed without strobe");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error flag outside an access phase");
endmodule
bind can_signal_mapper can_map_sva chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
  .tx_frame(tx_frame), .tx_ready(tx_ready), .rate_bus0(rate_bus0),
  .rate_bus1(rate_bus1), .phys_value(phys_value), .phys_strobe(phys_strobe));

// ---- tb/can_node_model.sv ----
// Other node on the bus: sends frames and takes transmitted ones
`timescale 1ns/1ps
module can_node_model (
  input wire logic clk,
  input wire logic rst,
  input wire can_map_pkg::can_frame_s tx_frame,
  output can_map_pkg::can_frame_s rx_frame,
  output logic tx_ready
);
  logic [1:0] mode = 2'h0; // 0 prompt, 1 random stalls, 2 holds off
  can_map_pkg::can_frame_s q[$];
  int t[$];
  int cyc = 0;
  initial begin
    rx_frame = '0;
    tx_ready = 1'b0;
  end
  // One frame per call, valid for one clock cycle
  task automatic send(input can_map_pkg::can_frame_s f);
    @(posedge clk);
    rx_frame <= f; // Frame driven as given; length not clamped
    @(posedge clk);
    rx_frame <= ~f; // Idle bus never echoes the last frame
  endtask
  // Taken frames are logged with their cycle so periods can be measured
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      if (tx_frame.valid === 1'b1 && tx_ready === 1'b1) begin
        q.push_back(tx_frame);
        t.push_back(cyc);
      end
      tx_ready <= mode == 0 ? 1'b1 : mode == 1 ? 1'($urandom % 2) : 1'b0;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the CAN signal mapper
`timescale 1ns/1ps
`include "can_map_params.svh"
module tb_top;
  localparam int TK = 10;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, tx_ready;
  logic phys_strobe, err, b;
  logic [7:0] paddr, r0;
  logic [31:0] pwdata, prdata, phys_value, v, g, o, r, lo, hi, e0;
  logic [15:0] rate_bus0, rate_bus1;
  logic [28:0] id, txi;
  logic [63:0] d;
  can_map_pkg::can_frame_s rx_frame, tx_frame, f;
  int failures = 0, checks_done = 0, cyc = 0, s, l;
  int rt[4] = '{125, 1000, 124, 1001};
  can_signal_mapper #(.TICK_CYCLES(TK)) uut (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame(rx_frame), .tx_frame(tx_frame), .tx_ready(tx_ready),
    .rate_bus0(rate_bus0), .rate_bus1(rate_bus1), .phys_value(phys_value),
    .phys_strobe(phys_strobe));
  can_node_model node (.clk(clk), .rst(rst), .tx_frame(tx_frame),
    .rx_frame(rx_frame), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp(input string n, input logic [127:0] e, input logic [127:0] x);
    checks_done++;
    if (x !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, x);
    end
  endtask
  // One APB transfer; an idle cycle after it keeps drivers apart
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
    paddr <= a;
    pwdata <= dt;
    pwrite <= w;
    psel <= 1'b1;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Reference field extraction: bytes or bits, little-endian payload
  function automatic logic [31:0] fld(logic [63:0] x, int st, int ln,
      logic br);
    return br ? 32'((x >> st) & ((64'h1 << ln) - 1)) :
      32'((x >> 8 * st) & ((64'h1 << 8 * ln) - 1));
  endfunction
  function automatic logic [31:0] phys(logic [31:0] rw, logic [15:0] gn,
      logic [31:0] of);
    longint p;
    p = longint'($signed(gn)) * longint'($signed(rw));
    return 32'(p >>> 8) + of;
  endfunction
  function automatic can_map_pkg::can_frame_s mk(logic bs, logic ex,
      logic [28:0] i, logic [63:0] dt);
    return '{1'b1, bs, ex, i, 4'h8, dt};
  endfunction
  // Send a frame, then look for the strobe and the raw value
  task rx(input can_map_pkg::can_frame_s fr, input logic hit,
      input logic [31:0] raw, input logic [31:0] ph);
    logic seen;
    seen = 1'b0;
    node.send(fr);
    repeat (4) begin
      @(posedge clk) #1;
      if (phys_strobe === 1'b1) begin
        seen = 1'b1;
        v = phys_value;
      end
    end
    @(posedge clk);
    cmp("strobe", hit, seen);
    if (hit) cmp("phys", ph, v);
    xfer(0, `CM_OFS_RX_RAW, 0);
    cmp("raw", raw, v);
  endtask
  task wait_tx(input int n);
    node.q.delete();
    node.t.delete();
    while (node.q.size() < n) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h3b74_0f40));
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(0, `CM_OFS_RATE, 0);
    cmp("rate_reg", 32'h01F4_01F4, v);
    xfer(0, 8'hFC, 0);
    cmp("unmapped", 33'h1_0000_0000, {err, v});
    // Rate limits: values just outside the range leave the old rate
    e0 = `CM_RATE_RST;
    foreach (rt[i]) begin
      xfer(1, `CM_OFS_RATE, {16'(rt[i]), 16'(rt[i])});
      if (rt[i] >= 125 && rt[i] <= 1000) e0 = rt[i];
      cmp("rate_bus", {2{e0[15:0]}}, {rate_bus1, rate_bus0});
    end
    // Standard identifier, byte then bit placement, three misfits each
    g = $urandom;
    o = $urandom;
    id = 29'($urandom) & 29'h0000_07FF;
    xfer(1, `CM_OFS_CTRL, 1);
    xfer(1, `CM_OFS_RX_GAIN, {16'h0000, g[15:0]});
    xfer(1, `CM_OFS_RX_OFFS, o);
    xfer(1, `CM_OFS_RX_ID, {3'h0, id});
    for (int i = 0; i < 2; i++) begin
      b = 1'(i);
      s = i ? 5 : 2;
      l = i ? 9 : 2;
      xfer(1, `CM_OFS_RX_FIELD, {15'h0000, b, 2'h0, 6'(l), 2'h0, 6'(s)});
      d = {$urandom, $urandom};
      r = fld(d, s, l, b);
      rx(mk(0, 0, id, d), 1, r, phys(r, g[15:0], o));
      rx(mk(0, 1, id, d), 0, r, 0);
      rx(mk(0, 0, id ^ 29'h1, d), 0, r, 0);
      rx(mk(1, 0, id, d), 0, r, 0);
    end
    // Extended id with row counter in byte 0, row 3 only
    id = 29'($urandom);
    xfer(1, `CM_OFS_RX_ID, {3'h6, id});
    xfer(1, `CM_OFS_RX_MUX, 32'h0000_0300);
    xfer(1, `CM_OFS_RX_FIELD, 32'h0000_0201);
    d = {$urandom, $urandom};
    d[7:0] = 8'h02;
    rx(mk(0, 1, id, d), 0, r, 0);
    d[7:0] = 8'h03;
    r = fld(d, 1, 2, 0);
    rx(mk(0, 1, id, d), 1, r, phys(r, g[15:0], o));
    // Silence longer than the timeout loads the replacement
    xfer(1, `CM_OFS_RX_REPL, 32'h0000_0055);
    xfer(1, `CM_OFS_RX_TMO, 32'h8000_0002);
    repeat (5 * TK) @(posedge clk);
    xfer(0, `CM_OFS_STATUS, 0);
    cmp("timed_out", 1'b1, v[1]);
    xfer(0, `CM_OFS_RX_RAW, 0);
    cmp("repl", 32'h0000_0055, v);
    xfer(1, `CM_OFS_RX_TMO, 0);
    // Periodic extended frame, partner stalling at random
    txi = 29'($urandom);
    lo = $urandom;
    hi = $urandom;
    node.mode <= 2'h1;
    xfer(1, `CM_OFS_TX_ID, {3'h4, txi});
    xfer(1, `CM_OFS_TX_LO, lo);
    xfer(1, `CM_OFS_TX_HI, hi);
    xfer(1, `CM_OFS_TX_PER, 3);
    xfer(1, `CM_OFS_CTRL, 3);
    wait_tx(3);
    foreach (node.q[k]) begin
      cmp("tx", mk(0, 1, txi, {hi, lo}), node.q[k]);
    end
    node.mode <= 2'h0;
    wait_tx(3);
    cmp("period", 3 * TK, node.t[2] - node.t[1]);
    // Two rows, counter in byte 7, data only in row 1, length 15 clamps
    xfer(1, `CM_OFS_TX_MUX, 32'h8F01_0207);
    wait_tx(1);
    wait_tx(4);
    r0 = node.q[0].data[63:56];
    foreach (node.q[k]) begin
      f = mk(0, 1, txi, ((r0 + k) & 1) ? {hi, lo} : 64'h0);
      f.data[63:56] = 8'((r0 + k) & 1);
      cmp("tx_row", f, node.q[k]);
    end
    // Gateway bus 0 to bus 1; first frame waits in the output slot,
    // second is held, and a third while one is held drops
    xfer(1, `CM_OFS_TX_PER, 0);
    xfer(1, `CM_OFS_CTRL, 32'h0000_0005);
    repeat (5) @(posedge clk);
    node.mode <= 2'h2;
    id = 29'($urandom);
    d = {$urandom, $urandom};
    node.send(mk(0, 1, id, d));
    repeat (4) @(posedge clk);
    node.send(mk(0, 1, id ^ 29'h2, ~d));
    repeat (4) @(posedge clk);
    node.send(mk(0, 0, id ^ 29'h4, d));
    repeat (4) @(posedge clk);
    xfer(0, `CM_OFS_STATUS, 0);
    cmp("drops", 8'h01, v[15:8]);
    cmp("gw_pending", 1'b1, v[2]);
    node.mode <= 2'h0;
    wait_tx(2);
    cmp("gateway", mk(1, 1, id, d), node.q[0]);
    cmp("gateway2", mk(1, 1, id ^ 29'h2, ~d), node.q[1]);
    tally_and_finish();
  end
endmodule
